// File: sdr_lat_pkg.sv
// Holds the SDR read latency table, read opcodes and lane helpers.
// Assumes both link ends agree on latency code and lane mapping.
package sdr_lat_pkg;
	// Read command families
	typedef enum logic [2:0] {
		fam_read, fam_fast, fam_dual_out, fam_quad_out, fam_dual_io, fam_quad_io, fam_none
	} read_fam_t;
	typedef struct packed {
		read_fam_t fam;
		logic a4;
	} cmd_t;
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] dummy;
	} lat_t;
	// Read opcodes, three and four address bytes
	localparam logic [7:0] OPC_READ3 = 8'h03;
	localparam logic [7:0] OPC_READ4 = 8'h13;
	localparam logic [7:0] OPC_FAST3 = 8'h0B;
	localparam logic [7:0] OPC_FAST4 = 8'h0C;
	localparam logic [7:0] OPC_DOUT3 = 8'h3B;
	localparam logic [7:0] OPC_DOUT4 = 8'h3C;
	localparam logic [7:0] OPC_QOUT3 = 8'h6B;
	localparam logic [7:0] OPC_QOUT4 = 8'h6C;
	localparam logic [7:0] OPC_DIO3 = 8'hBB;
	localparam logic [7:0] OPC_DIO4 = 8'hBC;
	localparam logic [7:0] OPC_QIO3 = 8'hEB;
	localparam logic [7:0] OPC_QIO4 = 8'hEC;
	// Latency codes and their clock bands
	localparam logic [1:0] CODE_50 = 2'h3;
	localparam logic [1:0] CODE_80 = 2'h0;
	localparam int BAND_50_KHZ = 50000;
	localparam int BAND_80_KHZ = 80000;
	// Table entries
	localparam logic [7:0] NOT_SUPP = 8'hFF;
	localparam logic [7:0] LAT_ZERO = 8'h00;
	localparam logic [7:0] DIO_DUMMY = 8'h04;
	localparam logic [7:0] QIO_MODE = 8'h02;
	localparam logic [7:0] QIO_DUMMY_50 = 8'h01;
	localparam logic [7:0] QIO_DUMMY_80 = 8'h04;
	localparam logic [7:0] DUMMY_80 = 8'h08;
	// Address widths in bits
	localparam logic [5:0] ADDR3_BITS = 6'h18;
	localparam logic [5:0] ADDR4_BITS = 6'h20;
	localparam logic [5:0] BYTE_BITS = 6'h08;
	// Serial clock made by the host from mclk
	localparam int MCLK_PERIOD_NS = 20;
	localparam int SCK_HALF = 4;
	localparam int SCK_PERIOD_NS = 2 * SCK_HALF * MCLK_PERIOD_NS;
	localparam int SCK_KHZ = 1000000 / SCK_PERIOD_NS;
	localparam logic [3:0] DIV_SMP = 4'(SCK_HALF - 1);
	localparam logic [3:0] DIV_RISE = 4'(SCK_HALF);
	localparam logic [3:0] DIV_LAST = 4'(2 * SCK_HALF - 1);

	// Mode and dummy cycles for a code and family, FFh when unsupported
	function automatic lat_t lat_of(input logic [1:0] code, input read_fam_t f);
		lat_t r;
		r = '{mode: NOT_SUPP, dummy: NOT_SUPP};
		if (code == CODE_50) begin
			case (f)
				fam_dual_io: r = '{mode: LAT_ZERO, dummy: DIO_DUMMY};
				fam_quad_io: r = '{mode: QIO_MODE, dummy: QIO_DUMMY_50};
				fam_none: r = '{mode: NOT_SUPP, dummy: NOT_SUPP};
				default: r = '{mode: LAT_ZERO, dummy: LAT_ZERO};
			endcase
		end else if (code == CODE_80) begin
			case (f)
				fam_read, fam_none: r = '{mode: NOT_SUPP, dummy: NOT_SUPP};
				fam_dual_io: r = '{mode: LAT_ZERO, dummy: DIO_DUMMY};
				fam_quad_io: r = '{mode: QIO_MODE, dummy: QIO_DUMMY_80};
				default: r = '{mode: LAT_ZERO, dummy: DUMMY_80};
			endcase
		end
		return r;
	endfunction : lat_of

	// Opcode to family
	function automatic cmd_t decode(input logic [7:0] opc);
		cmd_t c;
		c = '{fam: fam_none, a4: 1'b0};
		case (opc)
			OPC_READ3: c = '{fam: fam_read, a4: 1'b0};
			OPC_READ4: c = '{fam: fam_read, a4: 1'b1};
			OPC_FAST3: c = '{fam: fam_fast, a4: 1'b0};
			OPC_FAST4: c = '{fam: fam_fast, a4: 1'b1};
			OPC_DOUT3: c = '{fam: fam_dual_out, a4: 1'b0};
			OPC_DOUT4: c = '{fam: fam_dual_out, a4: 1'b1};
			OPC_QOUT3: c = '{fam: fam_quad_out, a4: 1'b0};
			OPC_QOUT4: c = '{fam: fam_quad_out, a4: 1'b1};
			OPC_DIO3: c = '{fam: fam_dual_io, a4: 1'b0};
			OPC_DIO4: c = '{fam: fam_dual_io, a4: 1'b1};
			OPC_QIO3: c = '{fam: fam_quad_io, a4: 1'b0};
			OPC_QIO4: c = '{fam: fam_quad_io, a4: 1'b1};
			default: c = '{fam: fam_none, a4: 1'b0};
		endcase
		return c;
	endfunction : decode

	// Family to opcode
	function automatic logic [7:0] encode(input read_fam_t f, input logic a4);
		case (f)
			fam_fast: return a4 ? OPC_FAST4 : OPC_FAST3;
			fam_dual_out: return a4 ? OPC_DOUT4 : OPC_DOUT3;
			fam_quad_out: return a4 ? OPC_QOUT4 : OPC_QOUT3;
			fam_dual_io: return a4 ? OPC_DIO4 : OPC_DIO3;
			fam_quad_io: return a4 ? OPC_QIO4 : OPC_QIO3;
			default: return a4 ? OPC_READ4 : OPC_READ3;
		endcase
	endfunction : encode

	// Log2 of lanes used for address and for data
	function automatic logic [1:0] addr_sh(input read_fam_t f);
		return (f == fam_quad_io) ? 2'h2 : ((f == fam_dual_io) ? 2'h1 : 2'h0);
	endfunction : addr_sh

	function automatic logic [1:0] data_sh(input read_fam_t f);
		case (f)
			fam_dual_out, fam_dual_io: return 2'h1;
			fam_quad_out, fam_quad_io: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction : data_sh

	function automatic logic [5:0] addr_cyc(input read_fam_t f, input logic a4);
		return (a4 ? ADDR4_BITS : ADDR3_BITS) >> addr_sh(f);
	endfunction : addr_cyc
endpackage : sdr_lat_pkg

// File: sdr_link_if.sv
// Holds the serial flash link between host and device ends.
// Assumes host makes sck and cs_n; lanes are pulled high when undriven.
`timescale 1ns/1ps
`default_nettype none
interface sdr_link_if;
	logic sck;
	logic cs_n;
	logic [3:0] host_io;
	logic [3:0] host_oe;
	logic [3:0] dev_io;
	logic [3:0] dev_oe;
	logic [3:0] io;

	// Lane resolution, device wins on overlap
	// Overlap only on io0 when data follows the address at once; the host
	// holds io0 until the next clock fall, too late for its sampler
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = dev_oe[i] ? dev_io[i] : (host_oe[i] ? host_io[i] : 1'b1);
		end
	end

	modport host (output sck, cs_n, host_io, host_oe, input io);
	modport device (input sck, cs_n, io, output dev_io, dev_oe);
endinterface : sdr_link_if
`default_nettype wire

// File: sdr_read_dev.sv
// Holds the flash end: decodes SDR reads and inserts mode and dummy cycles.
// Assumes all logic runs on the link sck; cs_n high clears the frame.
`timescale 1ns/1ps
`default_nettype none
module sdr_read_dev (
	sdr_link_if.device link,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [1:0] latency_code_setting_in,
	input wire logic [7:0] rd_data_in,
	output logic byte_load_out,
	output logic [31:0] addr_out,
	output logic [7:0] opcode_out,
	output logic cmd_refused_out
);
	typedef enum logic [2:0] {d_opc, d_addr, d_wait, d_data, d_ignore} dstate_t;
	typedef struct packed {
		dstate_t st;
		logic [5:0] cnt;
		logic [7:0] opc;
		sdr_lat_pkg::read_fam_t fam;
		logic a4;
		logic [31:0] addr;
		logic [8:0] wait_n;
		logic [7:0] dsh;
		logic [3:0] io;
		logic [3:0] oe;
	} dev_t;
	localparam dev_t D_RST = '{st: d_opc, fam: sdr_lat_pkg::fam_none, default: '0};

	dev_t s_q;
	dev_t s_d;
	logic frame_rstn;
	logic load;
	logic [7:0] opc_next;
	logic [3:0] din;
	logic [8:0] lat_sum;
	logic [1:0] ash;
	logic [1:0] dsh;
	sdr_lat_pkg::cmd_t dec;
	sdr_lat_pkg::lat_t lat;
	sdr_lat_pkg::lat_t lat_new;

	// Frame end clears all state while sck stands still
	assign frame_rstn = resetn_in & ~link.cs_n;

	// Next state of the read sequencer
	always_comb begin
		s_d = s_q;
		load = 1'b0;
		opc_next = {s_q.opc[6:0], link.io[0]};
		dec = sdr_lat_pkg::decode(opc_next);
		lat_new = sdr_lat_pkg::lat_of(latency_code_setting_in, dec.fam);
		lat = sdr_lat_pkg::lat_of(latency_code_setting_in, s_q.fam);
		lat_sum = {1'b0, lat.mode} + {1'b0, lat.dummy};
		ash = sdr_lat_pkg::addr_sh(s_q.fam);
		dsh = sdr_lat_pkg::data_sh(s_q.fam);
		case (ash)
			2'h1: din = {2'h0, link.io[1:0]};
			2'h2: din = link.io;
			default: din = {3'h0, link.io[0]};
		endcase
		case (s_q.st)
			d_opc: begin
				s_d.opc = opc_next;
				s_d.cnt = s_q.cnt + 6'h1;
				if (s_q.cnt == 6'h7) begin
					s_d.fam = dec.fam;
					s_d.a4 = dec.a4;
					s_d.cnt = 6'h0;
					// Unknown opcode or no entry at this code: stay off the lanes
					if (dec.fam == sdr_lat_pkg::fam_none || lat_new.mode == sdr_lat_pkg::NOT_SUPP) begin
						s_d.st = d_ignore;
					end else begin
						s_d.st = d_addr;
					end
				end
			end
			d_addr: begin
				s_d.addr = (s_q.addr << (3'h1 << ash)) | {28'h0, din};
				s_d.cnt = s_q.cnt + 6'h1;
				if (s_q.cnt == sdr_lat_pkg::addr_cyc(s_q.fam, s_q.a4) - 6'h1) begin
					if (lat_sum == 9'h0) begin
						load = 1'b1;
						s_d.st = d_data;
					end else begin
						s_d.wait_n = lat_sum;
						s_d.st = d_wait;
					end
				end
			end
			// Mode bits are taken and ignored, then dummy cycles pass
			d_wait: begin
				if (s_q.wait_n == 9'h1) begin
					load = 1'b1;
					s_d.st = d_data;
				end else begin
					s_d.wait_n = s_q.wait_n - 9'h1;
				end
			end
			d_data: begin
				if (s_q.cnt == (sdr_lat_pkg::BYTE_BITS >> dsh) - 6'h1) begin
					load = 1'b1;
					s_d.addr = s_q.addr + 32'h1;
				end else begin
					s_d.io = put_lanes(s_q.dsh, dsh);
					s_d.dsh = s_q.dsh << (3'h1 << dsh);
					s_d.cnt = s_q.cnt + 6'h1;
				end
			end
			default: s_d.oe = 4'h0;
		endcase
		// First lanes of a fresh byte go out on this edge
		if (load) begin
			s_d.io = put_lanes(rd_data_in, dsh);
			s_d.dsh = rd_data_in << (3'h1 << dsh);
			s_d.oe = (dsh == 2'h2) ? 4'hF : ((dsh == 2'h1) ? 4'h3 : 4'h2);
			s_d.cnt = 6'h0;
		end
	end

	// Top data bits onto lanes; single lane uses io1
	function automatic logic [3:0] put_lanes(input logic [7:0] b, input logic [1:0] sh);
		case (sh)
			2'h1: return {2'h0, b[7:6]};
			2'h2: return b[7:4];
			default: return {2'h0, b[7], 1'b0};
		endcase
	endfunction : put_lanes

	// State register on the link clock
	always_ff @(posedge link.sck or negedge frame_rstn) begin
		if (!frame_rstn) begin
			s_q <= D_RST;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign link.dev_io = s_q.io;
	assign link.dev_oe = s_q.oe;
	assign byte_load_out = load & ce_in;
	assign addr_out = s_q.addr;
	assign opcode_out = s_q.opc;
	assign cmd_refused_out = (s_q.st == d_ignore);
endmodule : sdr_read_dev
`default_nettype wire

// File: sdr_read_host.sv
// Holds the host end: issues SDR reads with matching mode and dummy cycles.
// Assumes mclk at 50 MHz; sck is divided from mclk and driven out.
//
// What this block does
// - Quad I/O read with four-byte address is ECh
// - Code 11b only with sck at most 50 MHz
// - Code 11b: plain, fast, dual/quad out zero cycles
// - Code 11b: dual I/O zero mode, four dummy
// - Code 11b: quad I/O two mode, one dummy
// - Code 00b only with sck at most 80 MHz
// - Code 00b: plain read never issued, entries FFh
// - Code 00b: fast, dual/quad out eight dummy
// - Code 00b: dual I/O four; quad I/O two+four
// - Families map to fixed three/four-byte opcode pairs
`timescale 1ns/1ps
`default_nettype none
module sdr_read_host (
	sdr_link_if.host link,
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire sdr_lat_pkg::read_fam_t fam_in,
	input wire logic addr4_in,
	input wire logic [31:0] addr_in,
	input wire logic [7:0] len_in,
	input wire logic [1:0] latency_code_setting_in,
	output logic ready_out,
	output logic refused_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic done_out
);
	typedef enum logic [2:0] {
		h_idle, h_opc, h_addr, h_mode, h_dummy, h_data, h_end
	} hstate_t;
	typedef struct packed {
		hstate_t st;
		logic [3:0] div;
		logic [5:0] cnt;
		logic [39:0] tx;
		sdr_lat_pkg::read_fam_t fam;
		logic a4;
		logic [7:0] mode;
		logic [7:0] dummy;
		logic [7:0] len;
		logic [7:0] rx;
		logic [7:0] rx_out;
		logic rx_vld;
		logic done;
		logic refused;
		logic cs_n;
		logic sck;
		logic [3:0] io;
		logic [3:0] oe;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] filt;
	} host_t;
	localparam host_t H_RST = '{
		st: h_idle, fam: sdr_lat_pkg::fam_none, cs_n: 1'b1, default: '0
	};

	host_t s_q;
	host_t s_d;
	logic tick;
	logic smp;
	logic last;
	logic band_ok;
	logic [1:0] ash;
	logic [1:0] dsh;
	logic [5:0] byte_cyc;
	logic [3:0] rbits;
	logic [7:0] rx_next;
	sdr_lat_pkg::lat_t lat;

	// Lane mask for address and mode bits
	function automatic logic [3:0] lane_mask(input logic [1:0] sh);
		return (sh == 2'h2) ? 4'hF : ((sh == 2'h1) ? 4'h3 : 4'h1);
	endfunction : lane_mask

	// Clock band of the chosen code against our own sck rate
	always_comb begin
		case (latency_code_setting_in)
			sdr_lat_pkg::CODE_50: band_ok = (sdr_lat_pkg::SCK_KHZ <= sdr_lat_pkg::BAND_50_KHZ);
			sdr_lat_pkg::CODE_80: band_ok = (sdr_lat_pkg::SCK_KHZ <= sdr_lat_pkg::BAND_80_KHZ);
			default: band_ok = 1'b0;
		endcase
	end

	// Sequencer, divider, sampler and lane synchroniser
	always_comb begin
		s_d = s_q;
		s_d.rx_vld = 1'b0;
		s_d.done = 1'b0;
		s_d.refused = 1'b0;
		tick = (s_q.div == 4'h0);
		smp = (s_q.div == sdr_lat_pkg::DIV_SMP);
		last = (s_q.div == sdr_lat_pkg::DIV_LAST);
		lat = sdr_lat_pkg::lat_of(latency_code_setting_in, fam_in);
		ash = sdr_lat_pkg::addr_sh(s_q.fam);
		dsh = sdr_lat_pkg::data_sh(s_q.fam);
		byte_cyc = sdr_lat_pkg::BYTE_BITS >> dsh;
		// Three flops; a lane changes once the second and third agree
		s_d.sync1 = link.io;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		s_d.filt = (~(s_q.sync2 ^ s_q.sync3) & s_q.sync3) | ((s_q.sync2 ^ s_q.sync3) & s_q.filt);
		case (dsh)
			2'h1: rbits = {2'h0, s_q.filt[1:0]};
			2'h2: rbits = s_q.filt;
			default: rbits = {3'h0, s_q.filt[1]};
		endcase
		rx_next = (s_q.rx << (3'h1 << dsh)) | {4'h0, rbits};
		if (s_q.st != h_idle) begin
			s_d.div = last ? 4'h0 : s_q.div + 4'h1;
		end
		case (s_q.st)
			h_idle: begin
				if (start_in) begin
					// Wrong band, unsupported entry or empty length is refused
					if (!band_ok || lat.mode == sdr_lat_pkg::NOT_SUPP || len_in == 8'h0
						|| fam_in == sdr_lat_pkg::fam_none) begin
						s_d.refused = 1'b1;
					end else begin
						s_d.st = h_opc;
						s_d.cs_n = 1'b0;
						s_d.div = 4'h0;
						s_d.cnt = 6'h7;
						s_d.tx[39:32] = sdr_lat_pkg::encode(fam_in, addr4_in);
						s_d.tx[31:0] = addr4_in ? addr_in : {addr_in[23:0], 8'h00};
						s_d.fam = fam_in;
						s_d.a4 = addr4_in;
						s_d.mode = lat.mode;
						s_d.dummy = lat.dummy;
						s_d.len = len_in;
					end
				end
			end
			// Opcode, one bit a cycle on io0
			h_opc: begin
				if (tick) begin
					s_d.io = {3'h0, s_q.tx[39]};
					s_d.oe = 4'h1;
					s_d.tx = s_q.tx << 1;
				end
				if (last) begin
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h0) begin
						s_d.st = h_addr;
						s_d.cnt = sdr_lat_pkg::addr_cyc(s_q.fam, s_q.a4) - 6'h1;
					end
				end
			end
			// Address on the family's address lanes, MSB first
			h_addr: begin
				if (tick) begin
					case (ash)
						2'h1: s_d.io = {2'h0, s_q.tx[39:38]};
						2'h2: s_d.io = s_q.tx[39:36];
						default: s_d.io = {3'h0, s_q.tx[39]};
					endcase
					s_d.oe = lane_mask(ash);
					s_d.tx = s_q.tx << (3'h1 << ash);
				end
				if (last) begin
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h0) begin
						if (s_q.mode != 8'h0) begin
							s_d.st = h_mode;
							s_d.cnt = s_q.mode[5:0] - 6'h1;
						end else if (s_q.dummy != 8'h0) begin
							s_d.st = h_dummy;
							s_d.cnt = s_q.dummy[5:0] - 6'h1;
						end else begin
							s_d.st = h_data;
							s_d.cnt = byte_cyc - 6'h1;
						end
					end
				end
			end
			// Mode bits driven as zero, no continuous read
			h_mode: begin
				if (tick) begin
					s_d.io = 4'h0;
					s_d.oe = lane_mask(ash);
				end
				if (last) begin
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h0) begin
						if (s_q.dummy != 8'h0) begin
							s_d.st = h_dummy;
							s_d.cnt = s_q.dummy[5:0] - 6'h1;
						end else begin
							s_d.st = h_data;
							s_d.cnt = byte_cyc - 6'h1;
						end
					end
				end
			end
			// Lanes released for the dummy cycles
			h_dummy: begin
				if (tick) begin
					s_d.oe = 4'h0;
				end
				if (last) begin
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h0) begin
						s_d.st = h_data;
						s_d.cnt = byte_cyc - 6'h1;
					end
				end
			end
			// Sample just before each rising edge; stop sck after last byte
			h_data: begin
				if (tick) begin
					s_d.oe = 4'h0;
				end
				if (smp) begin
					s_d.rx = rx_next;
					s_d.cnt = s_q.cnt - 6'h1;
					if (s_q.cnt == 6'h0) begin
						s_d.rx_out = rx_next;
						s_d.rx_vld = 1'b1;
						s_d.len = s_q.len - 8'h1;
						s_d.cnt = byte_cyc - 6'h1;
						if (s_q.len == 8'h1) begin
							s_d.st = h_end;
							s_d.cs_n = 1'b1;
						end
					end
				end
			end
			// Chip select high for the rest of the period
			h_end: begin
				s_d.oe = 4'h0;
				if (last) begin
					s_d.st = h_idle;
					s_d.done = 1'b1;
				end
			end
			default: s_d.st = h_idle;
		endcase
		if (s_d.st == h_idle) begin
			s_d.div = 4'h0;
		end
		s_d.sck = (s_d.st != h_idle) && (s_d.st != h_end) && (s_d.div >= sdr_lat_pkg::DIV_RISE);
	end

	// State register
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_q <= H_RST;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign link.sck = s_q.sck;
	assign link.cs_n = s_q.cs_n;
	assign link.host_io = s_q.io;
	assign link.host_oe = s_q.oe;
	assign ready_out = (s_q.st == h_idle);
	assign refused_out = s_q.refused;
	assign rx_data_out = s_q.rx_out;
	assign rx_valid_out = s_q.rx_vld;
	assign done_out = s_q.done;
endmodule : sdr_read_host
`default_nettype wire

// File: sdr_link_monitor.sv
// Holds protocol assertions on the serial link between host and flash ends.
// Assumes it sits beside the link interface, sampling on the host clock.
`timescale 1ns/1ps
`default_nettype none
module sdr_link_monitor (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] host_io,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_io,
	input wire logic [3:0] dev_oe
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	// Phases of the divided serial clock
	sequence low_phase;
		(!sck) [*4];
	endsequence
	sequence high_phase;
		sck [*4] ##1 !sck;
	endsequence

	// Serial clock shape and frame framing
	AST_SCK_HIGH: assert property ($rose(sck) |-> high_phase)
		else $error("serial clock high phase has wrong length");
	AST_SCK_LOW: assert property ($fell(sck) |-> low_phase)
		else $error("serial clock low phase too short");
	AST_CS_LEAD: assert property ($fell(cs_n) |-> low_phase ##1 sck)
		else $error("first clock rise not four cycles after select");
	AST_OPC_LANE: assert property ($fell(cs_n) |=> host_oe == 4'h1)
		else $error("opcode not sent on a single lane");
	AST_IDLE_SCK: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("serial clock moves outside a frame");
	AST_IDLE_LANES: assert property (cs_n && $past(cs_n) |-> host_oe == 4'h0 && dev_oe == 4'h0)
		else $error("lane driven outside a frame");
	// Lane ownership and edge discipline
	AST_NO_FIGHT: assert property ((host_oe[3:1] & dev_oe[3:1]) == 3'h0)
		else $error("host and device drive the same lane");
	AST_DEV_ON_RISE: assert property (!cs_n && $past(cs_n) == 1'b0
		&& ($changed(dev_io) || $changed(dev_oe)) |-> $rose(sck))
		else $error("device lanes change away from a clock rise");
	AST_HOST_ON_LOW: assert property (!cs_n && ($changed(host_io) || $changed(host_oe)) |-> !sck)
		else $error("host lanes change while clock is high");
endmodule : sdr_link_monitor
`default_nettype wire

// File: tb.sv
// Holds the self-checking bench joining host and flash ends over the link.
// Assumes the package, link interface, both ends and the monitor compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_in, resetn_in, start, a4, ready, refused, rx_valid, done, byte_load, dev_ref;
	sdr_lat_pkg::read_fam_t fam;
	logic [31:0] addr;
	logic [31:0] dev_addr;
	logic [7:0] len, rx_data, rd_data, dev_opc;
	logic [1:0] code_sel;
	logic pend;
	logic [31:0] addrq[$];
	int n_mismatch, cmp_count, seed, rises;
	logic [7:0] dataq[$];
	logic [7:0] opcq[$];
	logic refq[$];
	int cntq[$];
	logic [7:0] opc_tab [12] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
		8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC};

	sdr_link_if sif();
	sdr_read_host sdr_read_host_inst (.link(sif), .mclk_in(mclk_in), .resetn_in(resetn_in),
		.ce_in(1'b1), .start_in(start), .fam_in(fam), .addr4_in(a4), .addr_in(addr),
		.len_in(len), .latency_code_setting_in(code_sel), .ready_out(ready), .refused_out(refused),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .done_out(done));
	sdr_read_dev sdr_read_dev_inst (.link(sif), .resetn_in(resetn_in), .ce_in(1'b1),
		.latency_code_setting_in(code_sel), .rd_data_in(rd_data), .byte_load_out(byte_load),
		.addr_out(dev_addr), .opcode_out(dev_opc), .cmd_refused_out(dev_ref));
	sdr_link_monitor sdr_link_monitor_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.sck(sif.sck), .cs_n(sif.cs_n), .host_io(sif.host_io), .host_oe(sif.host_oe),
		.dev_io(sif.dev_io), .dev_oe(sif.dev_oe));

	// Clock source
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	// Compare helpers
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk8
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk32
	task automatic chk_cnt(input int got, input int exp, input string what);
		cmp_count++;
		if (got != exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask : chk_cnt

	// Mode plus dummy cycles per code and family
	function automatic int lat_cycles(input logic [1:0] code, input sdr_lat_pkg::read_fam_t f);
		case (f)
			sdr_lat_pkg::fam_dual_io: return 4;
			sdr_lat_pkg::fam_quad_io: return (code == 2'h3) ? 3 : 6;
			default: return (code == 2'h3) ? 0 : 8;
		endcase
	endfunction : lat_cycles
	// Lanes used for address or data
	function automatic int lanes(input sdr_lat_pkg::read_fam_t f, input bit data);
		case (f)
			sdr_lat_pkg::fam_dual_io: return 2;
			sdr_lat_pkg::fam_quad_io: return 4;
			sdr_lat_pkg::fam_dual_out: return data ? 2 : 1;
			sdr_lat_pkg::fam_quad_out: return data ? 4 : 1;
			default: return 1;
		endcase
	endfunction : lanes

	// One read request; notes its expected outcome first
	task automatic do_read(input logic [1:0] code, input sdr_lat_pkg::read_fam_t f,
		input logic w4, input logic [7:0] n);
		int t;
		logic rej;
		logic [31:0] a;
		rej = (code != 2'h3 && code != 2'h0) || n == 8'h00 || f == sdr_lat_pkg::fam_none
			|| (code == 2'h0 && f == sdr_lat_pkg::fam_read);
		refq.push_back(rej);
		a = $random(seed);
		if (!rej) begin
			cntq.push_back(8 + (w4 ? 32 : 24) / lanes(f, 0) + lat_cycles(code, f)
				+ int'(n) * 8 / lanes(f, 1) - 1);
			repeat (n) opcq.push_back(opc_tab[int'(f) * 2 + int'(w4)]);
			// Device address climbs by one per byte from the sent address
			for (int k = 0; k < int'(n); k++) begin
				addrq.push_back((w4 ? a : {8'h00, a[23:0]}) + 32'(k));
			end
		end
		@(negedge mclk_in);
		code_sel = code;
		fam = f;
		a4 = w4;
		addr = a;
		len = n;
		start = 1'b1;
		@(negedge mclk_in);
		start = 1'b0;
		t = 0;
		while (ready !== 1'b1 && t < 6000) begin
			@(negedge mclk_in);
			t++;
		end
		if (t >= 6000) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: read never finished", $time);
		end
	endtask : do_read

	// Flash-side byte source and watcher; a byte counts once a rise took it
	// The device asks for one byte past the end, which the frame end drops
	always @(negedge sif.sck or posedge sif.cs_n) begin
		if (sif.cs_n !== 1'b1 && pend === 1'b1) begin
			dataq.push_back(rd_data);
			chk8(dev_opc, (opcq.size() > 0) ? opcq.pop_front() : 8'hXX, "opcode");
			chk8({7'h00, dev_ref}, 8'h00, "device refusal");
			chk32(dev_addr, (addrq.size() > 0) ? addrq.pop_front() : 32'hX,
				"address");
		end
		pend = (sif.cs_n !== 1'b1) && (byte_load === 1'b1);
		if (pend) begin
			rd_data = 8'($random(seed));
		end
	end
	// Host watcher: bytes and completion kind
	always @(negedge mclk_in) begin
		if (rx_valid === 1'b1) begin
			chk8(rx_data, (dataq.size() > 0) ? dataq.pop_front() : 8'hXX, "byte");
		end
		if (refused === 1'b1 || done === 1'b1) begin
			chk8({7'h00, refused}, {7'h00, (refq.size() > 0) ? refq.pop_front() : 1'bX},
				"refusal");
		end
	end
	// Serial clock rises per frame
	always @(posedge sif.sck) begin
		if (sif.cs_n === 1'b0) begin
			rises++;
		end
	end
	always @(posedge sif.cs_n) begin
		if (resetn_in === 1'b1) begin
			chk_cnt(rises, (cntq.size() > 0) ? cntq.pop_front() : -1, "frame cycles");
		end
		rises = 0;
	end

	// Verdict and end of run
	task automatic final_report();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// Hang guard
	initial begin
		#1500000;
		n_mismatch++;
		final_report();
	end

	// Main sequence: codes 11b and 00b with every family and address width, then refusals and two more reads
	initial begin
		seed = 32'h5227A480;
		resetn_in = 1'b0;
		start = 1'b0;
		fam = sdr_lat_pkg::fam_fast;
		a4 = 1'b0;
		addr = 32'h0;
		len = 8'h01;
		code_sel = 2'h3;
		pend = 1'b0;
		rd_data = 8'h00;
		rises = 0;
		repeat (20) @(posedge mclk_in);
		@(negedge mclk_in);
		resetn_in = 1'b1;
		for (int c = 0; c < 2; c++) begin
			for (int f = 0; f < 6; f++) begin
				for (int w = 0; w < 2; w++) begin
					do_read(c ? 2'h0 : 2'h3, sdr_lat_pkg::read_fam_t'(f), w[0], 8'(1 + (f + w) % 3));
				end
			end
		end
		do_read(2'h1, sdr_lat_pkg::fam_fast, 1'b0, 8'h01);
		do_read(2'h2, sdr_lat_pkg::fam_quad_io, 1'b1, 8'h01);
		do_read(2'h3, sdr_lat_pkg::fam_fast, 1'b0, 8'h00);
		do_read(2'h3, sdr_lat_pkg::fam_none, 1'b0, 8'h01);
		do_read(2'h0, sdr_lat_pkg::fam_quad_io, 1'b1, 8'hFF);
		do_read(2'h3, sdr_lat_pkg::fam_dual_out, 1'b1, 8'h02);
		repeat (10) @(negedge mclk_in);
		chk_cnt(dataq.size() + refq.size() + cntq.size() + opcq.size() + addrq.size(), 0,
			"leftover notes");
		final_report();
	end
endmodule : tb
`default_nettype wire
